// [design/uhpc_hard_reset.sv]
// Purpose: spot two button presses inside the restore window
// Assumes: button input already debounced and synchronous
// Notes: a third press starts a fresh window
`timescale 1ns/100ps
module uhpc_hard_reset
  import uhpc_pkg::*;
#(
  parameter int unsigned WINDOW_CYCLES = HARD_RESET_WINDOW_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // button level, high while pressed
  input wire logic button,
  // one-cycle restore request
  output logic restore
);

  logic btn_q, btn_d;
  logic armed_q, armed_d;
  logic restore_q, restore_d;
  logic [31:0] cnt_q, cnt_d;
  logic press;

  assign press = button & ~btn_q;
  assign restore = restore_q;

  // window counter opened by the first press
  always_comb begin
    btn_d = button;
    armed_d = armed_q;
    restore_d = 1'b0;
    cnt_d = cnt_q;
    if (armed_q) begin
      cnt_d = cnt_q + 32'h00000001;
      if (cnt_q >= 32'(WINDOW_CYCLES - 1)) begin
        armed_d = 1'b0;
      end
    end
    if (press) begin
      if (armed_q) begin
        restore_d = 1'b1;
        armed_d = 1'b0;
      end else begin
        armed_d = 1'b1;
        cnt_d = 32'h00000000;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      btn_q <= 1'b0;
      armed_q <= 1'b0;
      restore_q <= 1'b0;
      cnt_q <= 32'h00000000;
    end else begin
      btn_q <= btn_d;
      armed_q <= armed_d;
      restore_q <= restore_d;
      cnt_q <= cnt_d;
    end
  end

endmodule : uhpc_hard_reset

// [design/uhpc_pkg.sv]
// Purpose: shared constants and types for the hub port control block
// Assumes: four downstream ports, two upstream connectors, 40 MHz core clock
// Notes: command codes follow the declaration order of uhpc_op_t
package uhpc_pkg;

  // clock and timing
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned STAGGER_TICK_MS = 1;
  localparam int unsigned STAGGER_TICK_CYCLES = CLK_HZ / MS_PER_S * STAGGER_TICK_MS;
  localparam int unsigned HARD_RESET_WINDOW_S = 5;
  localparam int unsigned HARD_RESET_WINDOW_CYCLES = CLK_HZ * HARD_RESET_WINDOW_S;

  // port counts
  localparam int unsigned N_DN = 4;
  localparam int unsigned HUB_MAP_USED = 8;

  // port state word fields
  localparam int unsigned ST_PWR_BIT = 0;
  localparam int unsigned ST_DATA_BIT = 1;
  localparam int unsigned ST_ERR_BIT = 19;
  localparam int unsigned ST_BOOST_BIT = 20;
  localparam int unsigned ST_ATT_BIT = 23;

  // port error word fields
  localparam int unsigned ER_OC_BIT = 0;
  localparam int unsigned ER_BD_BIT = 1;
  localparam int unsigned ER_OT_BIT = 3;

  // upstream policy and report codes
  localparam logic [1:0] UP_FORCE_PORT0 = 2'h0;
  localparam logic [1:0] UP_FORCE_PORT1 = 2'h1;
  localparam logic [1:0] UP_AUTO = 2'h2;
  localparam logic [1:0] UP_NONE = 2'h2;

  // charging mode codes and advertised budgets
  localparam logic CHG_SDP = 1'b0;
  localparam logic CHG_CDP = 1'b1;
  localparam int unsigned SDP_BUDGET_MA = 500;
  localparam int unsigned CDP_BUDGET_MA = 5000;

  // boost codes: 0, 4, 8, 12 percent
  localparam logic [1:0] BOOST_MAX = 2'h3;
  localparam logic [1:0] BOOST_OFF = 2'h0;

  // values after reset and after factory restore
  localparam logic [3:0] EN_DEF = 4'hf;
  localparam logic [3:0] CHG_DEF = 4'hf;
  localparam logic [15:0] DELAY_DEF_MS = 16'h0000;
  localparam logic [31:0] ILIM_DEF_UA = 32'h002625a0;

  // host commands
  typedef enum logic [4:0] {
    OP_PORT_EN, OP_PORT_DIS, OP_DATA_EN, OP_DATA_DIS, OP_HSDATA_EN, OP_HSDATA_DIS,
    OP_PWR_EN, OP_PWR_DIS, OP_GET_VOLT, OP_GET_CURR, OP_GET_ILIM, OP_SET_ILIM,
    OP_SET_CHG, OP_GET_CHG, OP_GET_SPEED, OP_GET_MAP, OP_SET_MAP, OP_GET_STATE,
    OP_GET_ERR, OP_GET_DELAY, OP_SET_DELAY, OP_CLR_ERR, OP_GET_UPMODE, OP_SET_UPMODE,
    OP_GET_UPSTATE, OP_GET_UPBOOST, OP_SET_UPBOOST, OP_GET_DNBOOST, OP_SET_DNBOOST, OP_SAVE
  } uhpc_op_t;

  // interleave data and power enables into the hub map word
  function automatic logic [31:0] uhpc_pack_map(input logic [3:0] data, input logic [3:0] pwr);
    logic [31:0] w;
    w = 32'h00000000;
    for (int i = 0; i < 4; i++) begin
      w[2*i] = data[i];
      w[2*i+1] = pwr[i];
    end
    return w;
  endfunction : uhpc_pack_map

endpackage : uhpc_pkg

// [design/uhpc_stagger.sv]
// Purpose: release downstream ports one at a time, port 0 first
// Assumes: start is a one-cycle pulse; delay in whole milliseconds
// Notes: the sequence also runs by itself out of reset
`timescale 1ns/100ps
module uhpc_stagger
  import uhpc_pkg::*;
#(
  parameter int unsigned MS_CYCLES = STAGGER_TICK_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // control
  input wire logic start,
  input wire logic [15:0] delay_ms,
  // released ports
  output logic [3:0] mask
);

  typedef enum logic [0:0] {SG_RUN, SG_DONE} uhpc_sg_t;

  uhpc_sg_t st_q, st_d;
  logic [3:0] mask_q, mask_d;
  logic [31:0] cyc_q, cyc_d;
  logic [15:0] ms_q, ms_d;

  assign mask = mask_q;

  // next state: open one more port after each full delay
  always_comb begin
    st_d = st_q;
    mask_d = mask_q;
    cyc_d = cyc_q;
    ms_d = ms_q;
    case (st_q)
      SG_RUN: begin
        if (ms_q >= delay_ms) begin
          mask_d = {mask_q[2:0], 1'b1};
          cyc_d = 32'h00000000;
          ms_d = 16'h0000;
          if (mask_q[2]) begin
            st_d = SG_DONE;
          end
        end else if (cyc_q >= 32'(MS_CYCLES - 1)) begin
          cyc_d = 32'h00000000;
          ms_d = ms_q + 16'h0001;
        end else begin
          cyc_d = cyc_q + 32'h00000001;
        end
      end
      default: begin
        st_d = SG_DONE;
      end
    endcase
    // restart from port 0 on a new upstream connection
    if (start) begin
      st_d = SG_RUN;
      mask_d = 4'h0;
      cyc_d = 32'h00000000;
      ms_d = 16'h0000;
    end
  end

  // registers; power-on starts the sequence
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      st_q <= SG_RUN;
      mask_q <= 4'h0;
      cyc_q <= 32'h00000000;
      ms_q <= 16'h0000;
    end else begin
      st_q <= st_d;
      mask_q <= mask_d;
      cyc_q <= cyc_d;
      ms_q <= ms_d;
    end
  end

endmodule : uhpc_stagger

// [design/uhpc_top.sv]
// Purpose: control and status core of a four-port hub with two upstream connectors
// Assumes: host commands arrive already framed, tagged with their upstream connector
// Notes: one command per cycle, answer one cycle later
`timescale 1ns/100ps
module uhpc_top
  import uhpc_pkg::*;
#(
  parameter int unsigned MS_CYCLES = STAGGER_TICK_CYCLES,
  parameter int unsigned WINDOW_CYCLES = HARD_RESET_WINDOW_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // host command port
  input wire logic cmd_valid,
  input wire logic cmd_src,
  input wire logic [4:0] cmd_op,
  input wire logic [1:0] cmd_chan,
  input wire logic [31:0] cmd_wdata,
  // host answer port
  output logic rsp_valid,
  output logic rsp_err,
  output logic [31:0] rsp_data,
  // upstream connectors
  input wire logic [1:0] up_vbus,
  output logic [1:0] up_active,
  output logic [1:0] up_boost,
  // downstream status inputs
  input wire logic [3:0] dn_attached,
  input wire logic [3:0] dn_hs_device,
  input wire logic [3:0] dn_overcurrent,
  input wire logic [3:0] dn_backdrive,
  input wire logic hub_overtemp,
  input wire logic [3:0][31:0] dn_volt_uv,
  input wire logic [3:0][31:0] dn_curr_ua,
  // downstream controls
  output logic [3:0] dn_data_en,
  output logic [3:0] dn_pwr_en,
  output logic [3:0] dn_cdp_adv,
  output logic [3:0] dn_dcp_adv,
  output logic [3:0][31:0] dn_ilim_ua,
  output logic [1:0] dn_boost,
  // persistent store and button
  input wire logic [1:0] nv_up_boost_in,
  input wire logic [1:0] nv_dn_boost_in,
  output logic nv_save,
  output logic [1:0] nv_up_boost,
  output logic [1:0] nv_dn_boost,
  input wire logic reset_button
);

  logic [3:0] data_q, data_d, pwr_q, pwr_d, chg_q, chg_d;
  logic [3:0][31:0] ilim_q, ilim_d;
  logic [15:0] delay_q, delay_d;
  logic [1:0] upmode_q, upmode_d, upsel_q, upsel_d;
  logic [1:0] upb_cfg_q, upb_cfg_d, dnb_cfg_q, dnb_cfg_d;
  logic [1:0] upb_nv_q, upb_nv_d, dnb_nv_q, dnb_nv_d;
  logic [1:0] upb_live_q, upb_live_d, dnb_live_q, dnb_live_d;
  logic [3:0] oc_q, oc_d, bd_q, bd_d;
  logic ot_q, ot_d;
  logic boot_q, save_q, save_d, host_q, host_d;
  logic rv_q, rv_d, re_q, re_d;
  logic [31:0] rd_q, rd_d;
  logic [3:0] dout_q, dout_d, pout_q, pout_d, cdp_q, cdp_d, dcp_q, dcp_d;
  logic [3:0] clr;
  logic [3:0] mask;
  logic restore, new_conn;
  logic [3:0] err_any;

  // per-port error flag for the state word
  assign err_any = oc_q | bd_q | {4{ot_q}};
  assign new_conn = host_d & (~host_q | (upsel_d != upsel_q));

  uhpc_stagger #(
    .MS_CYCLES(MS_CYCLES)
  ) u_stagger (
    .core_clk(core_clk),
    .resetn(resetn),
    .start(new_conn),
    .delay_ms(delay_q),
    .mask(mask)
  );

  uhpc_hard_reset #(
    .WINDOW_CYCLES(WINDOW_CYCLES)
  ) u_hard_reset (
    .core_clk(core_clk),
    .resetn(resetn),
    .button(reset_button),
    .restore(restore)
  );

  // build the state word of one port
  function automatic logic [31:0] state_word(input logic [1:0] ch, input logic [3:0] pw,
                                             input logic [3:0] dt, input logic [3:0] er,
                                             input logic bst, input logic [3:0] att);
    logic [31:0] w;
    w = 32'h00000000;
    w[ST_PWR_BIT] = pw[ch];
    w[ST_DATA_BIT] = dt[ch];
    w[ST_ERR_BIT] = er[ch];
    w[ST_BOOST_BIT] = bst;
    w[ST_ATT_BIT] = att[ch];
    return w;
  endfunction : state_word

  // upstream selection, fixed or automatic on bus power
  always_comb begin
    upsel_d = upsel_q;
    if (upmode_q == UP_FORCE_PORT0) begin
      upsel_d = 2'h0;
    end else if (upmode_q == UP_FORCE_PORT1) begin
      upsel_d = 2'h1;
    end else if (upsel_q != UP_NONE && up_vbus[upsel_q[0]]) begin
      upsel_d = upsel_q; // keep a live host rather than hop between them
    end else if (up_vbus[0]) begin
      upsel_d = 2'h0;
    end else if (up_vbus[1]) begin
      upsel_d = 2'h1;
    end else begin
      upsel_d = UP_NONE;
    end
    host_d = (upsel_d != UP_NONE) && up_vbus[upsel_d[0]];
  end

  // command decode and register file next values
  always_comb begin
    data_d = data_q;
    pwr_d = pwr_q;
    chg_d = chg_q;
    ilim_d = ilim_q;
    delay_d = delay_q;
    upmode_d = upmode_q;
    upb_cfg_d = upb_cfg_q;
    dnb_cfg_d = dnb_cfg_q;
    upb_nv_d = upb_nv_q;
    dnb_nv_d = dnb_nv_q;
    upb_live_d = upb_live_q;
    dnb_live_d = dnb_live_q;
    save_d = 1'b0;
    clr = 4'h0;
    rv_d = 1'b0;
    re_d = 1'b0;
    rd_d = 32'h00000000;
    // saved boost becomes live only at the first cycle after a reset
    if (boot_q) begin
      upb_live_d = nv_up_boost_in;
      dnb_live_d = nv_dn_boost_in;
    end
    if (cmd_valid) begin
      rv_d = 1'b1;
      if (upsel_q == UP_NONE || upsel_q[0] != cmd_src) begin
        re_d = 1'b1;
      end else begin
        case (uhpc_op_t'(cmd_op))
          OP_PORT_EN: begin data_d[cmd_chan] = 1'b1; pwr_d[cmd_chan] = 1'b1; end
          OP_PORT_DIS: begin data_d[cmd_chan] = 1'b0; pwr_d[cmd_chan] = 1'b0; end
          OP_DATA_EN, OP_HSDATA_EN: data_d[cmd_chan] = 1'b1;
          OP_DATA_DIS, OP_HSDATA_DIS: data_d[cmd_chan] = 1'b0;
          OP_PWR_EN: pwr_d[cmd_chan] = 1'b1;
          OP_PWR_DIS: pwr_d[cmd_chan] = 1'b0;
          OP_GET_VOLT: rd_d = dn_volt_uv[cmd_chan];
          OP_GET_CURR: rd_d = dn_curr_ua[cmd_chan];
          OP_GET_ILIM: rd_d = ilim_q[cmd_chan];
          OP_SET_ILIM: ilim_d[cmd_chan] = cmd_wdata;
          OP_SET_CHG: begin
            if (cmd_wdata[31:1] != 31'h00000000) begin
              re_d = 1'b1;
            end else begin
              chg_d[cmd_chan] = cmd_wdata[0];
            end
          end
          OP_GET_CHG: rd_d = {31'h00000000, chg_q[cmd_chan]};
          OP_GET_SPEED: rd_d = {31'h00000000, dn_attached[cmd_chan] & dn_hs_device[cmd_chan]};
          OP_GET_MAP: rd_d = uhpc_pack_map(data_q, pwr_q);
          OP_SET_MAP: begin
            for (int i = 0; i < N_DN; i++) begin
              data_d[i] = cmd_wdata[2*i];
              pwr_d[i] = cmd_wdata[2*i+1];
            end
          end
          OP_GET_STATE: rd_d = state_word(cmd_chan, pwr_q, data_q, err_any, dnb_live_q != BOOST_OFF,
                                          dn_attached);
          OP_GET_ERR: begin
            rd_d[ER_OC_BIT] = oc_q[cmd_chan];
            rd_d[ER_BD_BIT] = bd_q[cmd_chan];
            rd_d[ER_OT_BIT] = ot_q;
          end
          OP_GET_DELAY: rd_d = {16'h0000, delay_q};
          OP_SET_DELAY: delay_d = cmd_wdata[15:0];
          OP_CLR_ERR: clr[cmd_chan] = 1'b1;
          OP_GET_UPMODE: rd_d = {30'h00000000, upmode_q};
          OP_SET_UPMODE: begin
            if (cmd_wdata > 32'(UP_AUTO)) begin
              re_d = 1'b1;
            end else begin
              upmode_d = cmd_wdata[1:0];
            end
          end
          OP_GET_UPSTATE: rd_d = {30'h00000000, upsel_q};
          OP_GET_UPBOOST: rd_d = {30'h00000000, upb_cfg_q};
          OP_GET_DNBOOST: rd_d = {30'h00000000, dnb_cfg_q};
          OP_SET_UPBOOST, OP_SET_DNBOOST: begin
            if (cmd_wdata > 32'(BOOST_MAX)) begin
              re_d = 1'b1;
            end else if (cmd_op == OP_SET_UPBOOST) begin
              upb_cfg_d = cmd_wdata[1:0];
            end else begin
              dnb_cfg_d = cmd_wdata[1:0];
            end
          end
          OP_SAVE: begin
            upb_nv_d = upb_cfg_q;
            dnb_nv_d = dnb_cfg_q;
            save_d = 1'b1;
          end
          default: re_d = 1'b1;
        endcase
      end
    end
    // factory restore overrides a command in the same cycle, except an upstream mode write
    if (restore) begin
      data_d = EN_DEF;
      pwr_d = EN_DEF;
      chg_d = CHG_DEF;
      delay_d = DELAY_DEF_MS;
      ilim_d = {N_DN{ILIM_DEF_UA}};
      upb_cfg_d = BOOST_OFF;
      dnb_cfg_d = BOOST_OFF;
      upb_nv_d = BOOST_OFF;
      dnb_nv_d = BOOST_OFF;
      upb_live_d = BOOST_OFF;
      dnb_live_d = BOOST_OFF;
      save_d = 1'b1;
    end
  end

  // sticky errors; a new event beats a clear in the same cycle
  always_comb begin
    oc_d = (oc_q & ~clr) | dn_overcurrent;
    bd_d = (bd_q & ~clr) | dn_backdrive;
    ot_d = ot_q | hub_overtemp;
  end

  // pin drive: stagger gate and charger advertisement
  always_comb begin
    dout_d = data_q & mask;
    pout_d = pwr_q & mask;
    cdp_d = chg_q & {4{host_q}};
    dcp_d = chg_q & {4{~host_q}};
  end

  // registers
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      data_q <= EN_DEF;
      pwr_q <= EN_DEF;
      chg_q <= CHG_DEF;
      ilim_q <= {N_DN{ILIM_DEF_UA}};
      delay_q <= DELAY_DEF_MS;
      upmode_q <= UP_AUTO;
      upsel_q <= UP_NONE;
      upb_cfg_q <= BOOST_OFF;
      dnb_cfg_q <= BOOST_OFF;
      upb_nv_q <= BOOST_OFF;
      dnb_nv_q <= BOOST_OFF;
      upb_live_q <= BOOST_OFF;
      dnb_live_q <= BOOST_OFF;
      oc_q <= 4'h0;
      bd_q <= 4'h0;
      ot_q <= 1'b0;
      boot_q <= 1'b1;
      save_q <= 1'b0;
      host_q <= 1'b0;
      rv_q <= 1'b0;
      re_q <= 1'b0;
      rd_q <= 32'h00000000;
      dout_q <= 4'h0;
      pout_q <= 4'h0;
      cdp_q <= 4'h0;
      dcp_q <= 4'h0;
    end else begin
      data_q <= data_d;
      pwr_q <= pwr_d;
      chg_q <= chg_d;
      ilim_q <= ilim_d;
      delay_q <= delay_d;
      upmode_q <= upmode_d;
      upsel_q <= upsel_d;
      upb_cfg_q <= upb_cfg_d;
      dnb_cfg_q <= dnb_cfg_d;
      upb_nv_q <= upb_nv_d;
      dnb_nv_q <= dnb_nv_d;
      upb_live_q <= upb_live_d;
      dnb_live_q <= dnb_live_d;
      oc_q <= oc_d;
      bd_q <= bd_d;
      ot_q <= ot_d;
      boot_q <= 1'b0;
      save_q <= save_d;
      host_q <= host_d;
      rv_q <= rv_d;
      re_q <= re_d;
      rd_q <= rd_d;
      dout_q <= dout_d;
      pout_q <= pout_d;
      cdp_q <= cdp_d;
      dcp_q <= dcp_d;
    end
  end

  // outputs straight from flops
  assign rsp_valid = rv_q;
  assign rsp_err = re_q;
  assign rsp_data = rd_q;
  assign up_active = upsel_q;
  assign up_boost = upb_live_q;
  assign dn_boost = dnb_live_q;
  assign dn_data_en = dout_q;
  assign dn_pwr_en = pout_q;
  assign dn_cdp_adv = cdp_q;
  assign dn_dcp_adv = dcp_q;
  assign dn_ilim_ua = ilim_q;
  assign nv_save = save_q;
  assign nv_up_boost = upb_nv_q;
  assign nv_dn_boost = dnb_nv_q;

endmodule : uhpc_top

// [verif/uhpc_host_model.sv]
// Purpose: host on the upstream connectors of the hub
// Assumes: one command in flight at a time
// Notes: write bus is scrambled once released
`timescale 1ns/100ps
module uhpc_host_model (
  // clock
  input wire logic core_clk,
  // answer from the hub
  input wire logic rsp_valid,
  input wire logic rsp_err,
  input wire logic [31:0] rsp_data,
  // command to the hub
  output logic cmd_valid,
  output logic cmd_src,
  output logic [4:0] cmd_op,
  output logic [1:0] cmd_chan,
  output logic [31:0] cmd_wdata,
  // bus power per connector
  output logic [1:0] up_vbus
);
  // idle, no host plugged
  initial begin
    cmd_valid = 1'b0;
    cmd_src = 1'b0;
    cmd_op = 5'h1f;
    cmd_chan = 2'h0;
    cmd_wdata = 32'h0;
    up_vbus = 2'h0;
  end
  // plug or pull hosts
  task automatic plug(input logic [1:0] v);
    @(posedge core_clk);
    up_vbus <= v;
  endtask : plug
  // one command, answer read just after the take edge
  task automatic send(input logic [4:0] o, input logic [1:0] c, input logic [31:0] v, input logic s,
                      output logic [32:0] r);
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_src <= s;
    cmd_op <= o;
    cmd_chan <= c;
    cmd_wdata <= v;
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    cmd_wdata <= ~v; // no stale value left
    #1;
    r = rsp_valid ? {rsp_err, rsp_data} : 33'hx;
  endtask : send
endmodule : uhpc_host_model

// [verif/uhpc_properties.sv]
// Purpose: port-level checks of the hub control core
// Assumes: one clock, synchronous active-low reset
// Notes: bound to the core from the bench top file
`timescale 1ns/100ps
module uhpc_checker (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // command and answer
  input wire logic cmd_valid,
  input wire logic cmd_src,
  input wire logic [4:0] cmd_op,
  input wire logic [1:0] cmd_chan,
  input wire logic rsp_valid,
  input wire logic rsp_err,
  input wire logic [31:0] rsp_data,
  // status
  input wire logic [1:0] up_active,
  input wire logic [3:0] dn_attached,
  input wire logic [3:0] dn_hs_device,
  input wire logic [3:0] dn_cdp_adv,
  input wire logic [3:0] dn_dcp_adv
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // a command taken from the active connector, then one of a given kind
  sequence s_ok;
    cmd_valid && up_active == {1'b0, cmd_src};
  endsequence
  sequence s_rd(op);
    s_ok ##0 (cmd_op == op);
  endsequence
  chk_rsp_follows: assert property (cmd_valid |=> rsp_valid) else $error("answer missing");
  chk_rsp_cause: assert property (rsp_valid |-> $past(cmd_valid)) else $error("answer without command");
  chk_wrong_src: assert property (cmd_valid && up_active != {1'b0, cmd_src} |=> rsp_err) else $error("foreign cmd");
  chk_bad_op: assert property (cmd_valid && cmd_op > 5'h1d |=> rsp_err) else $error("bad op taken");
  chk_err_zero: assert property (rsp_err |-> rsp_data == 32'h0) else $error("refusal carries data");
  chk_map_rsvd: assert property (s_rd(5'h0f) |=> !rsp_err && rsp_data[31:8] == 24'h0) else $error("map");
  chk_state_rsvd: assert property (s_rd(5'h11) |=> (rsp_data & 32'hff67fffc) == 0) else $error("state");
  chk_err_rsvd: assert property (s_rd(5'h12) |=> (rsp_data & 32'hfffffff4) == 0) else $error("errors");
  chk_speed_code: assert property (s_rd(5'h0e) |=>
    rsp_data == {31'h0, $past(dn_attached[cmd_chan] & dn_hs_device[cmd_chan])}) else $error("speed");
  chk_adv_excl: assert property ((dn_cdp_adv & dn_dcp_adv) == 4'h0) else $error("both adverts");
  chk_up_code: assert property (up_active != 2'h3) else $error("upstream code");
endmodule : uhpc_checker

// [verif/uhpc_top_test.sv]
// Purpose: self-checking bench for the hub control core
// Assumes: shortened ms tick and restore window
// Notes: all commands go through the host model
`timescale 1ns/100ps
module uhpc_top_test import uhpc_pkg::*;;
  localparam int MS = 4;
  localparam logic [32:0] ERR = 33'h100000000;
  logic core_clk, resetn, cmd_valid, cmd_src, rsp_valid, rsp_err, hub_overtemp, nv_save, reset_button, src;
  logic [4:0] cmd_op, op;
  logic [1:0] cmd_chan, up_vbus, up_active, up_boost, dn_boost, nv_up_boost_in, nv_dn_boost_in;
  logic [1:0] nv_up_boost, nv_dn_boost;
  logic [31:0] cmd_wdata, rsp_data, w;
  logic [3:0] dn_attached, dn_hs_device, dn_overcurrent, dn_backdrive, dn_data_en, dn_pwr_en;
  logic [3:0] dn_cdp_adv, dn_dcp_adv, de, pe;
  logic [3:0][31:0] dn_volt_uv, dn_curr_ua, dn_ilim_ua;
  int n_fail = 0, samples_checked = 0, n_save = 0, n;
  uhpc_top #(.MS_CYCLES(MS), .WINDOW_CYCLES(100)) dut (.core_clk, .resetn, .cmd_valid, .cmd_src, .cmd_op,
    .cmd_chan, .cmd_wdata, .rsp_valid, .rsp_err, .rsp_data, .up_vbus, .up_active, .up_boost, .dn_attached,
    .dn_hs_device, .dn_overcurrent, .dn_backdrive, .hub_overtemp, .dn_volt_uv, .dn_curr_ua, .dn_data_en,
    .dn_pwr_en, .dn_cdp_adv, .dn_dcp_adv, .dn_ilim_ua, .dn_boost, .nv_up_boost_in, .nv_dn_boost_in,
    .nv_save, .nv_up_boost, .nv_dn_boost, .reset_button);
  uhpc_host_model host (.core_clk, .rsp_valid, .rsp_err, .rsp_data, .cmd_valid, .cmd_src, .cmd_op,
    .cmd_chan, .cmd_wdata, .up_vbus);
  // 40 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // save pulses seen
  always @(posedge core_clk) if (resetn && nv_save) n_save++;
  function automatic logic [32:0] ok(input logic [31:0] v);
    return {1'b0, v};
  endfunction : ok
  function automatic logic [31:0] mp(input logic [3:0] d, input logic [3:0] p);
    return {24'h0, p[3], d[3], p[2], d[2], p[1], d[1], p[0], d[0]};
  endfunction : mp
  task automatic finish_test;
    if (n_fail == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic run(input logic [4:0] o, input logic [1:0] c, input logic [31:0] v, input logic [32:0] e);
    logic [32:0] r;
    host.send(o, c, v, src, r);
    check(r, e);
  endtask : run
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask : tick
  // hang guard, far above the expected run
  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    finish_test();
  end
  // main sequence
  initial begin
    void'($urandom(74));
    {resetn, reset_button, hub_overtemp, src} = 4'h1;
    {dn_attached, dn_hs_device, dn_overcurrent, dn_backdrive} = 16'h0;
    nv_up_boost_in = 2'h2;
    nv_dn_boost_in = 2'h1;
    for (int i = 0; i < 4; i++) {dn_volt_uv[i], dn_curr_ua[i]} = {$urandom, $urandom};
    host.plug(2'b10);
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    tick(4);
    check({up_active, up_boost, dn_boost}, 6'h19);
    src = 1'b0;
    run(OP_GET_MAP, 0, 0, ERR);
    src = 1'b1;
    run(OP_GET_MAP, 0, 0, ok(32'hff));
    run(OP_GET_UPSTATE, 0, 0, ok(1));
    for (int i = 0; i < 6; i++) begin
      w = i ? $urandom : 32'hffffff00;
      run(OP_SET_MAP, 0, w, ok(0));
      run(OP_GET_MAP, 0, 0, ok(w[7:0]));
      de = {w[6], w[4], w[2], w[0]};
      pe = {w[7], w[5], w[3], w[1]};
    end
    tick(3);
    check({dn_data_en, dn_pwr_en}, {de, pe});
    for (int i = 0; i < 24; i++) begin
      op = 5'($urandom_range(7));
      n = $urandom_range(3);
      run(op, n, 0, ok(0));
      if (op < 6) de[n] = !op[0];
      if (op < 2 || op > 5) pe[n] = !op[0];
      run(OP_GET_MAP, 0, 0, ok(mp(de, pe)));
    end
    {dn_attached, dn_hs_device, dn_overcurrent, dn_backdrive, hub_overtemp} <= {8'($urandom), 9'h83};
    tick(1);
    {dn_overcurrent, dn_backdrive, hub_overtemp} <= 9'h0;
    for (int c = 0; c < 4; c++) begin
      w = $urandom;
      run(OP_GET_SPEED, c, 0, ok(dn_attached[c] & dn_hs_device[c]));
      run(OP_GET_STATE, c, 0, ok({8'h0, dn_attached[c], 4'h3, 17'h0, de[c], pe[c]}));
      run(OP_GET_ERR, c, 0, ok({28'h0, 2'b10, c == 0, c == 2}));
      run(OP_GET_VOLT, c, 0, ok(dn_volt_uv[c]));
      run(OP_GET_CURR, c, 0, ok(dn_curr_ua[c]));
      run(OP_SET_ILIM, c, w, ok(0));
      run(OP_GET_ILIM, c, 0, ok(w));
      check(dn_ilim_ua[c], w);
    end
    run(OP_CLR_ERR, 2, 0, ok(0));
    run(OP_GET_ERR, 2, 0, ok(8));
    run(OP_GET_ERR, 0, 0, ok(32'ha));
    run(OP_SET_CHG, 0, 2, ERR);
    run(OP_SET_CHG, 1, 0, ok(0));
    run(OP_GET_CHG, 1, 0, ok(0));
    run(OP_SET_MAP, 0, 32'hff, ok(0));
    run(OP_SET_DELAY, 0, 2, ok(0));
    run(OP_GET_DELAY, 0, 0, ok(2));
    check({dn_cdp_adv, dn_dcp_adv}, 8'hd0);
    host.plug(2'b00);
    tick(3);
    check({up_active, dn_cdp_adv, dn_dcp_adv}, 10'h20d);
    run(OP_GET_MAP, 0, 0, ERR);
    host.plug(2'b01);
    n = 0;
    for (int i = 0; i < 60; i++) begin
      tick(1);
      if (dn_pwr_en != 4'hf) n++;
      check(dn_pwr_en inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hf}, 1);
    end
    // port 0 also waits one full delay after the connection, so four gaps
    check(n >= 8 * MS && n <= 8 * MS + 8, 1);
    src = 1'b0;
    run(OP_GET_UPSTATE, 0, 0, ok(0));
    run(OP_SET_UPMODE, 0, 3, ERR);
    run(OP_SET_UPMODE, 0, 1, ok(0));
    src = 1'b1;
    run(OP_GET_UPMODE, 0, 0, ok(1));
    run(OP_SET_UPMODE, 0, 0, ok(0));
    src = 1'b0;
    run(OP_SET_UPMODE, 0, 2, ok(0));
    run(OP_GET_UPSTATE, 0, 0, ok(0));
    for (int k = 0; k < 5; k++) begin
      run(OP_SET_UPBOOST, 0, k, k > 3 ? ERR : ok(0));
      run(OP_GET_UPBOOST, 0, 0, ok(k > 3 ? 3 : k));
    end
    run(OP_SET_DNBOOST, 0, 0, ok(0));
    run(OP_SET_DNBOOST, 0, 4, ERR);
    run(OP_GET_DNBOOST, 0, 0, ok(0));
    run(5'h1e, 0, 0, ERR);
    run(OP_SAVE, 0, 0, ok(0));
    tick(3);
    check({up_boost, dn_boost, nv_up_boost, nv_dn_boost, n_save[1:0]}, 10'h271);
    repeat (2) begin
      reset_button <= 1'b1;
      tick(3);
      reset_button <= 1'b0;
      tick(5);
    end
    check({up_boost, dn_boost, n_save[1:0]}, 6'h2);
    run(OP_GET_MAP, 0, 0, ok(32'hff));
    run(OP_GET_CHG, 1, 0, ok(1));
    run(OP_GET_DELAY, 0, 0, ok(0));
    run(OP_GET_ILIM, 3, 0, ok(32'd2500000));
    finish_test();
  end
endmodule : uhpc_top_test
bind uhpc_top uhpc_checker u_chk (.core_clk, .resetn, .cmd_valid, .cmd_src, .cmd_op, .cmd_chan, .rsp_valid,
  .rsp_err, .rsp_data, .up_active, .dn_attached, .dn_hs_device, .dn_cdp_adv, .dn_dcp_adv);
